// ### dv/gp_timer_module_one_asserts.sv
// Checker for the timer block's bus handshake and outputs.
// Assumes it is bound to the timer module and sees only its ports.
`timescale 1ns/10ps
module gp_timer_checks (
  // Clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  // Bus
  input wire logic        awvalid_in,
  input wire logic        awready_out,
  input wire logic        wvalid_in,
  input wire logic        wready_out,
  input wire logic        bvalid_out,
  input wire logic        bready_in,
  input wire logic [1:0]  bresp_out,
  input wire logic        arvalid_in,
  input wire logic        arready_out,
  input wire logic        rvalid_out,
  input wire logic        rready_in,
  input wire logic [31:0] rdata_out,
  input wire logic [1:0]  rresp_out,
  // Pins
  input wire logic        toggle_output_pin_out,
  input wire logic        irq_out
);
  // ----
  // Properties
  // ----
  default clocking dc @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_n_in);
  chk_b_stands: assert property (bvalid_out && !bready_in |=> bvalid_out && $stable(bresp_out))
    else $error("write response dropped");
  chk_r_stands: assert property (rvalid_out && !rready_in |=> rvalid_out && $stable(rdata_out))
    else $error("read data dropped");
  chk_w_refused: assert property (bvalid_out |-> !awready_out && !wready_out)
    else $error("write taken while answering");
  chk_ar_refused: assert property (rvalid_out |-> !arready_out)
    else $error("read taken while answering");
  chk_read_lat: assert property (arvalid_in && arready_out |=> rvalid_out)
    else $error("read answer late");
  chk_write_lat: assert property (awvalid_in && awready_out && wvalid_in && wready_out
    |-> ##[1:2] bvalid_out) else $error("write answer late");
  chk_upper_zero: assert property (rvalid_out |-> rdata_out[31:16] == 16'h0000)
    else $error("upper half not zero");
  chk_err_data: assert property (rvalid_out && rresp_out == 2'h2 |-> rdata_out == 32'h0)
    else $error("error read carries data");
  chk_reset_idle: assert property ($rose(rst_n_in) |-> !bvalid_out && !rvalid_out
    && !irq_out && !toggle_output_pin_out) else $error("outputs busy after reset");
  // Main scenarios reached
  cover property (rvalid_out && rresp_out == 2'h2);
  cover property ($rose(irq_out));
  cover property ($fell(toggle_output_pin_out));
endmodule

// ### dv/pin_model.sv
// Pin-side model: gate or clock pins and direction or phase-B pins.
// Assumes the bench calls its tasks from one process at a time.
`timescale 1ns/10ps
module pin_model (
  // Clock
  input  wire logic       clk_sys_in,
  // Pins toward the block
  output logic      [2:0] gate_pins_out,
  output logic      [2:0] dir_pins_out
);
  // Idle levels
  initial begin
    gate_pins_out = 3'h0;
    dir_pins_out = 3'h0;
  end
  // One pin change right after an edge
  task automatic set_pin(input int i, input logic g, input logic v);
    @(posedge clk_sys_in);
    if (g) gate_pins_out[i] <= v;
    else dir_pins_out[i] <= v;
  endtask
  // Pulse held long enough for the synchroniser
  task automatic pulse(input int i, input int h);
    set_pin(i, 1'b1, 1'b1);
    repeat (h) @(posedge clk_sys_in);
    set_pin(i, 1'b0 ^ 1'b1, 1'b0);
    repeat (h) @(posedge clk_sys_in);
  endtask
  // Sensor phases, A leads B when moving up
  task automatic quad(input int i, input logic up, input int n, input int h);
    logic a;
    logic b;
    for (int k = 0; k < n; k++) begin
      a = gate_pins_out[i];
      b = dir_pins_out[i];
      if ((a == b) == up) set_pin(i, 1'b1, !a);
      else set_pin(i, 1'b0, !b);
      repeat (h) @(posedge clk_sys_in);
    end
  endtask
endmodule

// ### dv/tb.sv
// Bench for the three-timer block: bus tasks, pin model, scoreboard.
// Assumes the package, map header and pin model are compiled first.
`timescale 1ns/10ps
`include "gp_timer_map.svh"
module tb;
  // ----
  // Signals
  // ----
  typedef struct {string nm; logic [31:0] ex; logic [31:0] mk; logic [1:0] rs;} note_s;
  logic        clk_sys_in, rst_n_in, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, tog, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [2:0]  gpin, dpin;
  int          err_total, check_count, seed, n;
  note_s       nt, rq[$];
  logic [1:0]  bq[$];
  // Clock
  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end
  gp_timer_module_one i_dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .awvalid_in(awvalid), .awready_out(awready),
    .awaddr_in(awaddr), .wvalid_in(wvalid), .wready_out(wready), .wdata_in(wdata),
    .wstrb_in(4'h3), .bvalid_out(bvalid), .bready_in(bready), .bresp_out(bresp),
    .arvalid_in(arvalid), .arready_out(arready), .araddr_in(araddr), .rvalid_out(rvalid),
    .rready_in(rready), .rdata_out(rdata), .rresp_out(rresp),
    .timer_gate_clock_input_in(gpin), .timer_direction_input_in(dpin),
    .toggle_output_pin_out(tog), .irq_out(irq));
  pin_model i_pins (.clk_sys_in(clk_sys_in), .gate_pins_out(gpin), .dir_pins_out(dpin));
  // ----
  // Tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task tally_and_finish;
    if (err_total == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er = 2'h0);
    bq.push_back(er);
    @(posedge clk_sys_in);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= {16'h0000, d};
    bready <= 1'($random(seed) & 1);
    do begin
      @(posedge clk_sys_in);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    // Late ready: the answer must stand until taken
    do @(posedge clk_sys_in); while (!bvalid);
    if (!bready) begin
      bready <= 1'b1;
      @(posedge clk_sys_in);
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input string nm, input logic [15:0] e,
                    input logic [15:0] m = 16'hFFFF, input logic [1:0] er = 2'h0);
    rq.push_back('{nm, {16'h0000, e}, {16'hFFFF, m}, er});
    @(posedge clk_sys_in);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'($random(seed) & 1);
    do @(posedge clk_sys_in); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk_sys_in); while (!rvalid);
    if (!rready) begin
      rready <= 1'b1;
      @(posedge clk_sys_in);
    end
    rready <= 1'b0;
  endtask
  task automatic span(output int c);
    logic v;
    v = tog;
    c = 0;
    do begin
      @(posedge clk_sys_in);
      c++;
    end while (tog === v);
  endtask
  function automatic logic [15:0] ctl(input logic [1:0] md, input logic [15:0] x);
    return x | {14'h0, md} | (16'h1 << `CTL_RUN);
  endfunction
  // Scoreboard: oldest note against each answer
  always @(posedge clk_sys_in) begin
    if (bvalid && bready) chk("bresp", 32'(bresp), 32'(bq.pop_front()));
    if (rvalid && rready) begin
      nt = rq.pop_front();
      chk(nt.nm, rdata & nt.mk, nt.ex & nt.mk);
      chk("rresp", 32'(rresp), 32'(nt.rs));
    end
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_total++;
    tally_and_finish;
  end
  // Main sequence
  initial begin
    seed = 13;
    {rst_n_in, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    repeat (6) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    rd(`OFS_CTRL_CORE, "ctrl_core", 16'h0000);
    rd(`OFS_CNT_B, "cnt_b", 16'h0000);
    rd(8'h28, "unmapped", 16'h0000, 16'hFFFF, `RESP_SLVERR);
    wr(8'h28, 16'h1234, `RESP_SLVERR);
    wr(`OFS_CNT_CORE, 16'hFFFE);
    wr(`OFS_IRQ_EN, 16'h0001);
    wr(`OFS_CTRL_CORE, ctl(gp_timer_pkg::MODE_TIMER, 16'h0));
    repeat (20) @(posedge clk_sys_in);
    chk("toggle", 32'(tog), 32'h1);
    chk("irq", 32'(irq), 32'h1);
    wr(`OFS_CTRL_CORE, 16'h0000);
    rd(`OFS_IRQ_STS, "sts", 16'h0001, 16'h0001);
    wr(`OFS_IRQ_EN, 16'h0000);
    repeat (2) @(posedge clk_sys_in);
    chk("irq_masked", 32'(irq), 32'h0);
    wr(`OFS_IRQ_EN, 16'h0001);
    wr(`OFS_IRQ_CLR, 16'h0001);
    repeat (2) @(posedge clk_sys_in);
    chk("irq_cleared", 32'(irq), 32'h0);
    wr(`OFS_CNT_CORE, 16'h0000);
    wr(`OFS_CTRL_CORE, ctl(gp_timer_pkg::MODE_TIMER, 16'h1 << `CTL_PRESC_LSB));
    repeat (80) @(posedge clk_sys_in);
    wr(`OFS_CTRL_CORE, 16'h0000);
    rd(`OFS_CNT_CORE, "rate", 16'h0008, 16'hFFFC);
    wr(`OFS_CNT_A, 16'h0000);
    wr(`OFS_CTRL_A, ctl(gp_timer_pkg::MODE_GATED, 16'h0));
    repeat (60) @(posedge clk_sys_in);
    i_pins.set_pin(1, 1'b1, 1'b1);
    repeat (17) @(posedge clk_sys_in);
    wr(`OFS_CTRL_A, 16'h0000);
    rd(`OFS_CNT_A, "gated", 16'h0004);
    i_pins.set_pin(1, 1'b1, 1'b0);
    wr(`OFS_CNT_A, 16'h0064);
    i_pins.set_pin(1, 1'b0, 1'b1);
    wr(`OFS_CTRL_A, ctl(gp_timer_pkg::MODE_TIMER, 16'h1 << `CTL_DIRPIN));
    repeat (40) @(posedge clk_sys_in);
    wr(`OFS_CTRL_A, 16'h0000);
    rd(`OFS_CNT_A, "dir_pin", 16'h0050, 16'hFFF0);
    rd(`OFS_STATUS, "pin_sync", 16'h0021, 16'h007F);
    i_pins.set_pin(1, 1'b0, 1'b0);
    for (int e = 1; e < 4; e++) begin
      wr(`OFS_CNT_B, 16'h0000);
      wr(`OFS_CTRL_B, ctl(gp_timer_pkg::MODE_COUNT, 16'(e) << `CTL_EDGE_LSB));
      repeat (3) i_pins.pulse(2, 8 + ($random(seed) & 7));
      wr(`OFS_CTRL_B, 16'h0000);
      rd(`OFS_CNT_B, "events", (e == 3) ? 16'h0006 : 16'h0003);
    end
    wr(`OFS_CNT_CORE, 16'h0000);
    wr(`OFS_CTRL_CORE, ctl(gp_timer_pkg::MODE_QUAD, 16'h0));
    i_pins.quad(0, 1'b1, 7, 6 + ($random(seed) & 3));
    i_pins.quad(0, 1'b0, 3, 6);
    wr(`OFS_CTRL_CORE, 16'h0000);
    rd(`OFS_CNT_CORE, "quad", 16'h0004);
    wr(`OFS_CNT_A, 16'h0000);
    wr(`OFS_CTRL_A, ctl(gp_timer_pkg::MODE_COUNT, 16'h0B00));
    wr(`OFS_CNT_CORE, 16'hFFFE);
    wr(`OFS_CTRL_CORE, ctl(gp_timer_pkg::MODE_TIMER, 16'h0));
    repeat (20) @(posedge clk_sys_in);
    wr(`OFS_CTRL_CORE, 16'h0000);
    rd(`OFS_CNT_A, "latch_src", 16'h0001);
    wr(`OFS_CNT_CORE, 16'h1234);
    wr(`OFS_CNT_A, 16'h0055);
    wr(`OFS_CTRL_A, ctl(gp_timer_pkg::MODE_TIMER, 16'h1100));
    i_pins.pulse(1, 10);
    rd(`OFS_CNT_A, "capture", 16'h1234);
    rd(`OFS_IRQ_STS, "sts_a", 16'h0002, 16'h0002);
    wr(`OFS_CTRL_A, 16'h0000);
    wr(`OFS_CNT_B, 16'h0ABC);
    wr(`OFS_CTRL_B, ctl(gp_timer_pkg::MODE_TIMER, 16'h2100));
    i_pins.pulse(2, 10);
    rd(`OFS_CNT_CORE, "reload", 16'h0ABC);
    rd(`OFS_CNT_B, "aux_held", 16'h0ABC);
    wr(`OFS_CNT_A, 16'hFFFD);
    wr(`OFS_CNT_B, 16'hFFFB);
    wr(`OFS_CTRL_A, ctl(gp_timer_pkg::MODE_TIMER, 16'h6000));
    wr(`OFS_CTRL_B, ctl(gp_timer_pkg::MODE_TIMER, 16'hA000));
    wr(`OFS_CNT_CORE, 16'hFFF0);
    wr(`OFS_CTRL_CORE, ctl(gp_timer_pkg::MODE_TIMER, 16'h0));
    do @(posedge clk_sys_in); while (tog !== 1'b1);
    do @(posedge clk_sys_in); while (tog !== 1'b0);
    span(n);
    chk("pwm_low", 32'(n), 32'd20);
    span(n);
    chk("pwm_high", 32'(n), 32'd12);
    tally_and_finish;
  end
endmodule
bind gp_timer_module_one gp_timer_checks i_chk (
  .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .awvalid_in(awvalid_in),
  .awready_out(awready_out), .wvalid_in(wvalid_in), .wready_out(wready_out),
  .bvalid_out(bvalid_out), .bready_in(bready_in), .bresp_out(bresp_out),
  .arvalid_in(arvalid_in), .arready_out(arready_out), .rvalid_out(rvalid_out),
  .rready_in(rready_in), .rdata_out(rdata_out), .rresp_out(rresp_out),
  .toggle_output_pin_out(toggle_output_pin_out), .irq_out(irq_out));

// ### inc/gp_timer_map.svh
// Register offsets, control field positions, reset values, tick constants.
// Assumes inclusion by bare name from the bench and the timer module.
`ifndef GP_TIMER_MAP_SVH
`define GP_TIMER_MAP_SVH
// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OFS_CTRL_CORE  8'h00
`define OFS_CTRL_A     8'h04
`define OFS_CTRL_B     8'h08
`define OFS_CNT_CORE   8'h0C
`define OFS_CNT_A      8'h10
`define OFS_CNT_B      8'h14
`define OFS_IRQ_STS    8'h18
`define OFS_IRQ_CLR    8'h1C
`define OFS_IRQ_EN     8'h20
`define OFS_STATUS     8'h24
// ------------------------------------------------------------
// Control register field positions
// ------------------------------------------------------------
`define CTL_MODE_LSB   0
`define CTL_RUN        2
`define CTL_DIR        3
`define CTL_DIRPIN     4
`define CTL_PRESC_LSB  5
`define CTL_EDGE_LSB   8
`define CTL_GATE_LOW   10
`define CTL_OTL_SRC    11
`define CTL_AUX_LSB    12
`define CTL_TRIG_LSB   14
// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define CTRL_RST       16'h0000
`define CNT_RST        16'h0000
`define IEN_RST        3'h0
`define RESOLUTION_CLKS 4
`define PRE_MASK_ALL   10'h3FF
`define PRE_SHIFT_MAX  4'h8
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// ### inc/gp_timer_pkg.sv
// Types shared by the timer module: modes, control fields, state record.
// Assumes the map header is on the include path.
package gp_timer_pkg;
  // ------------------------------------------------------------
  // Enumerations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_TIMER = 2'b00, MODE_GATED = 2'b01, MODE_COUNT = 2'b10, MODE_QUAD = 2'b11
  } tmr_mode_e;
  typedef enum logic [1:0] {
    AUX_COUNT = 2'b00, AUX_CAPTURE = 2'b01, AUX_RELOAD = 2'b10, AUX_RSVD = 2'b11
  } aux_cfg_e;
  typedef enum logic [3:0] {
    SEL_CTRL0 = 4'h0, SEL_CTRL1 = 4'h1, SEL_CTRL2 = 4'h2, SEL_CNT0 = 4'h3,
    SEL_CNT1 = 4'h4, SEL_CNT2 = 4'h5, SEL_ISTS = 4'h6, SEL_ICLR = 4'h7,
    SEL_IEN = 4'h8, SEL_STAT = 4'h9, SEL_NONE = 4'hF
  } reg_sel_e;
  // ------------------------------------------------------------
  // Records
  // ------------------------------------------------------------
  typedef struct packed {
    tmr_mode_e  mode;
    logic       run;
    logic       dir;
    logic       dir_pin;
    logic [2:0] presc;
    logic [1:0] edge_sel;
    logic       gate_low;
    logic       otl_src;
    aux_cfg_e   aux;
    logic [1:0] trig;
  } tmr_ctrl_s;
  typedef struct packed {
    logic [2:0][15:0] ctrl;
    logic [2:0][15:0] cnt;
    logic [2:0]       pend;
    logic [5:0]       s1;
    logic [5:0]       s2;
    logic [5:0]       s3;
    logic [5:0]       stb;
    logic             otl;
    logic             otl_d;
    logic [9:0]       pre;
    logic [2:0]       ists;
    logic [2:0]       ien;
    logic             irq;
    logic             aw_have;
    logic             w_have;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
  } state_s;
endpackage

// ### rtl/gp_timer_module_one.sv
// Three 16-bit timers (core, aux a, aux b) with AXI4-Lite registers.
// Assumes pins are asynchronous to clk_sys_in; one clock, sync reset.
// Contract
// - 16-bit timers, chainable through toggle latch
// - timer, gated, counter, quadrature modes
// - timer mode counts prescaled system clock
// - counter mode counts input pin events
// - gated mode counts while gate active
// - one input pin: gate or clock
// - at most one step per four clocks, except quadrature mode
// - direction by bit, optionally by pin
// - quadrature decodes two sensor phases
// - core latch toggles on wrap
// - latch drives toggle output pin
// - latch can clock either aux timer
// - aux capture/reload stops aux counting
// - capture copies core on pin event
// - reload core by pin or latch edge
// - opposite-edge reloads alternate for PWM
`timescale 1ns/10ps
`include "gp_timer_map.svh"
module gp_timer_module_one (
  // Clock and reset
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  // AXI4-Lite write address
  input  wire logic        awvalid_in,
  output logic             awready_out,
  input  wire logic [7:0]  awaddr_in,
  // AXI4-Lite write data
  input  wire logic        wvalid_in,
  output logic             wready_out,
  input  wire logic [31:0] wdata_in,
  input  wire logic [3:0]  wstrb_in,
  // AXI4-Lite write response
  output logic             bvalid_out,
  input  wire logic        bready_in,
  output logic [1:0]       bresp_out,
  // AXI4-Lite read address
  input  wire logic        arvalid_in,
  output logic             arready_out,
  input  wire logic [7:0]  araddr_in,
  // AXI4-Lite read data
  output logic             rvalid_out,
  input  wire logic        rready_in,
  output logic [31:0]      rdata_out,
  output logic [1:0]       rresp_out,
  // Timer pins: index 0 core, 1 aux a, 2 aux b
  input  wire logic [2:0]  timer_gate_clock_input_in,
  input  wire logic [2:0]  timer_direction_input_in,
  // Outputs
  output logic             toggle_output_pin_out,
  output logic             irq_out
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  gp_timer_pkg::state_s s_r;
  gp_timer_pkg::state_s s_nxt;

  // ------------------------------------------------------------
  // Functions
  // ------------------------------------------------------------
  // Split a raw control word into fields
  function automatic gp_timer_pkg::tmr_ctrl_s ctrl_fn(input logic [15:0] r);
    gp_timer_pkg::tmr_ctrl_s c;
    c.mode     = gp_timer_pkg::tmr_mode_e'(r[`CTL_MODE_LSB +: 2]);
    c.run      = r[`CTL_RUN];
    c.dir      = r[`CTL_DIR];
    c.dir_pin  = r[`CTL_DIRPIN];
    c.presc    = r[`CTL_PRESC_LSB +: 3];
    c.edge_sel = r[`CTL_EDGE_LSB +: 2];
    c.gate_low = r[`CTL_GATE_LOW];
    c.otl_src  = r[`CTL_OTL_SRC];
    c.aux      = gp_timer_pkg::aux_cfg_e'(r[`CTL_AUX_LSB +: 2]);
    c.trig     = r[`CTL_TRIG_LSB +: 2];
    return c;
  endfunction

  // Prescaled tick: once per 4 * 2^p clocks
  // One free-running counter keeps all timers in step
  function automatic logic tick_fn(input logic [9:0] pre, input logic [2:0] p);
    logic [9:0] m;
    m = `PRE_MASK_ALL >> (`PRE_SHIFT_MAX - {1'b0, p});
    return &(pre | ~m);
  endfunction

  // Edge select: bit 0 rising, bit 1 falling
  function automatic logic edge_fn(input logic [1:0] sel, input logic r,
                                   input logic f);
    return (sel[0] & r) | (sel[1] & f);
  endfunction

  // Address decode shared by read and write
  function automatic gp_timer_pkg::reg_sel_e sel_fn(input logic [7:0] a);
    case (a)
      `OFS_CTRL_CORE: return gp_timer_pkg::SEL_CTRL0;
      `OFS_CTRL_A:    return gp_timer_pkg::SEL_CTRL1;
      `OFS_CTRL_B:    return gp_timer_pkg::SEL_CTRL2;
      `OFS_CNT_CORE:  return gp_timer_pkg::SEL_CNT0;
      `OFS_CNT_A:     return gp_timer_pkg::SEL_CNT1;
      `OFS_CNT_B:     return gp_timer_pkg::SEL_CNT2;
      `OFS_IRQ_STS:   return gp_timer_pkg::SEL_ISTS;
      `OFS_IRQ_CLR:   return gp_timer_pkg::SEL_ICLR;
      `OFS_IRQ_EN:    return gp_timer_pkg::SEL_IEN;
      `OFS_STATUS:    return gp_timer_pkg::SEL_STAT;
      default:        return gp_timer_pkg::SEL_NONE;
    endcase
  endfunction

  // Byte-lane merge into a 16-bit register
  function automatic logic [15:0] merge_fn(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0] st);
    logic [15:0] v;
    v = old;
    if (st[0]) begin
      v[7:0] = d[7:0];
    end
    if (st[1]) begin
      v[15:8] = d[15:8];
    end
    return v;
  endfunction

  // ------------------------------------------------------------
  // Bus handshakes
  // ------------------------------------------------------------
  // One write and one read in flight at most
  // Ready drops while an answer waits, so none is lost
  assign awready_out = !s_r.aw_have && !s_r.bvalid;
  assign wready_out  = !s_r.w_have && !s_r.bvalid;
  assign arready_out = !s_r.rvalid;
  // Registered outputs
  assign bvalid_out            = s_r.bvalid;
  assign bresp_out             = s_r.bresp;
  assign rvalid_out            = s_r.rvalid;
  assign rdata_out             = s_r.rdata;
  assign rresp_out             = s_r.rresp;
  assign toggle_output_pin_out = s_r.otl;
  assign irq_out               = s_r.irq;

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    gp_timer_pkg::tmr_ctrl_s c [3];
    gp_timer_pkg::reg_sel_e  ws;
    gp_timer_pkg::reg_sel_e  rs;
    logic [5:0]  rise;
    logic [5:0]  fall;
    logic [2:0]  step;
    logic [2:0]  dn;
    logic [2:0]  pin_ev;
    logic [2:0]  set;
    logic [2:0]  clr;
    logic [15:0] rv;
    logic        base;
    logic        otl_r;
    logic        otl_f;
    logic        src_ev;
    logic        a_ev;
    logic        b_ev;
    logic        trig;

    s_nxt  = s_r;
    ws     = gp_timer_pkg::SEL_NONE;
    rs     = gp_timer_pkg::SEL_NONE;
    rise   = 6'h00;
    fall   = 6'h00;
    step   = 3'h0;
    dn     = 3'h0;
    pin_ev = 3'h0;
    set    = 3'h0;
    clr    = 3'h0;
    rv     = 16'h0000;
    base   = 1'b0;
    otl_r  = 1'b0;
    otl_f  = 1'b0;
    src_ev = 1'b0;
    a_ev   = 1'b0;
    b_ev   = 1'b0;
    trig   = 1'b0;

    for (int k = 0; k < 3; k++) begin
      c[k] = ctrl_fn(s_r.ctrl[k]);
    end

    // Pin synchroniser, stable once stages two and three agree
    // Stage one feeds only stage two, never the logic
    s_nxt.s1 = {timer_direction_input_in, timer_gate_clock_input_in};
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    for (int k = 0; k < 6; k++) begin
      if (s_r.s2[k] == s_r.s3[k]) begin
        s_nxt.stb[k] = s_r.s3[k];
      end
    end

    // Edges from the filtered level; idle and reset are low
    rise = s_nxt.stb & ~s_r.stb;
    fall = ~s_nxt.stb & s_r.stb;

    // Prescaler and latch edge history
    // Latch edges reach aux logic one cycle after the toggle
    s_nxt.pre   = s_r.pre + 10'h001;
    base        = (s_r.pre[1:0] == 2'b11);
    s_nxt.otl_d = s_r.otl;
    otl_r       = s_r.otl & ~s_r.otl_d;
    otl_f       = ~s_r.otl & s_r.otl_d;

    // Per-timer counting
    for (int i = 0; i < 3; i++) begin
      pin_ev[i] = edge_fn(c[i].edge_sel, rise[i], fall[i]);
      dn[i]     = c[i].dir ^ (c[i].dir_pin & s_r.stb[3+i]);
      if (i > 0 && c[i].otl_src) begin
        src_ev = edge_fn(c[i].edge_sel, otl_r, otl_f);
      end else begin
        src_ev = pin_ev[i];
      end

      // Any change on either phase pin
      a_ev = rise[i] | fall[i];
      b_ev = rise[3+i] | fall[3+i];
      // Stale events dropped outside counter mode
      s_nxt.pend[i] = 1'b0;
      unique case (c[i].mode)
        gp_timer_pkg::MODE_TIMER: begin
          step[i] = c[i].run & tick_fn(s_r.pre, c[i].presc);
        end
        gp_timer_pkg::MODE_GATED: begin
          step[i] = c[i].run & tick_fn(s_r.pre, c[i].presc)
                    & (s_r.stb[i] ^ c[i].gate_low);
        end
        gp_timer_pkg::MODE_COUNT: begin
          // Events wait for the next base tick
          s_nxt.pend[i] = s_r.pend[i] | src_ev;
          step[i]       = c[i].run & base & s_nxt.pend[i];
          // Events seen while stopped are not kept
          if (base || !c[i].run) begin
            s_nxt.pend[i] = 1'b0;
          end
        end
        gp_timer_pkg::MODE_QUAD: begin
          // Phase A on clock pin, phase B on direction pin
          // Both phases moving together is dropped as noise
          step[i] = c[i].run & (a_ev ^ b_ev);
          if (a_ev) begin
            dn[i] = ~(s_nxt.stb[i] ^ s_r.stb[3+i]) ^ c[i].dir;
          end else begin
            dn[i] = (s_nxt.stb[3+i] ^ s_r.stb[i]) ^ c[i].dir;
          end
        end
      endcase

      // Aux in capture or reload role is held
      if (i > 0 && (c[i].aux == gp_timer_pkg::AUX_CAPTURE ||
                    c[i].aux == gp_timer_pkg::AUX_RELOAD)) begin
        step[i] = 1'b0;
      end

      if (step[i]) begin
        s_nxt.cnt[i] = dn[i] ? s_r.cnt[i] - 16'h0001 : s_r.cnt[i] + 16'h0001;
        if (dn[i] ? (s_r.cnt[i] == 16'h0000) : (s_r.cnt[i] == 16'hFFFF)) begin
          set[i] = 1'b1;
          if (i == 0) begin
            s_nxt.otl = ~s_r.otl;
          end
        end
      end
    end

    // Capture into aux, reload core from aux
    // Aux b is handled last, so it wins a shared trigger
    for (int j = 1; j < 3; j++) begin
      if (c[j].aux == gp_timer_pkg::AUX_CAPTURE && pin_ev[j]) begin
        s_nxt.cnt[j] = s_r.cnt[0];
        set[j]       = 1'b1;
      end
      if (c[j].aux == gp_timer_pkg::AUX_RELOAD) begin
        unique case (c[j].trig)
          2'b00: trig = pin_ev[j];
          2'b01: trig = otl_r;
          2'b10: trig = otl_f;
          2'b11: trig = otl_r | otl_f;
        endcase
        // Rising and falling reloads from the two aux alternate
        if (trig) begin
          s_nxt.cnt[0] = s_r.cnt[j];
          set[j]       = 1'b1;
        end
      end
    end

    // Write channel capture
    if (awvalid_in && awready_out) begin
      s_nxt.aw_have = 1'b1;
      s_nxt.awaddr  = awaddr_in;
    end
    if (wvalid_in && wready_out) begin
      s_nxt.w_have = 1'b1;
      s_nxt.wdata  = wdata_in;
      s_nxt.wstrb  = wstrb_in;
    end
    if (s_r.bvalid && bready_in) begin
      s_nxt.bvalid = 1'b0;
    end

    // Register write once address and data are both held
    // Counter and control writes come last and override hardware updates
    if (s_r.aw_have && s_r.w_have) begin
      ws            = sel_fn(s_r.awaddr);
      s_nxt.aw_have = 1'b0;
      s_nxt.w_have  = 1'b0;
      s_nxt.bvalid  = 1'b1;
      s_nxt.bresp   = `RESP_OKAY;
      unique case (ws)
        gp_timer_pkg::SEL_CTRL0: s_nxt.ctrl[0] = merge_fn(s_r.ctrl[0], s_r.wdata, s_r.wstrb);
        gp_timer_pkg::SEL_CTRL1: s_nxt.ctrl[1] = merge_fn(s_r.ctrl[1], s_r.wdata, s_r.wstrb);
        gp_timer_pkg::SEL_CTRL2: s_nxt.ctrl[2] = merge_fn(s_r.ctrl[2], s_r.wdata, s_r.wstrb);
        gp_timer_pkg::SEL_CNT0:  s_nxt.cnt[0]  = merge_fn(s_r.cnt[0], s_r.wdata, s_r.wstrb);
        gp_timer_pkg::SEL_CNT1:  s_nxt.cnt[1]  = merge_fn(s_r.cnt[1], s_r.wdata, s_r.wstrb);
        gp_timer_pkg::SEL_CNT2:  s_nxt.cnt[2]  = merge_fn(s_r.cnt[2], s_r.wdata, s_r.wstrb);
        gp_timer_pkg::SEL_ICLR:  clr = s_r.wstrb[0] ? s_r.wdata[2:0] : 3'h0;
        gp_timer_pkg::SEL_IEN: begin
          if (s_r.wstrb[0]) begin
            s_nxt.ien = s_r.wdata[2:0];
          end
        end
        gp_timer_pkg::SEL_ISTS, gp_timer_pkg::SEL_STAT: begin
          s_nxt.bresp = `RESP_OKAY; // Read-only, write ignored
        end
        default: s_nxt.bresp = `RESP_SLVERR;
      endcase
    end

    // Sticky flags, a new event beats a clear
    // Irq changes on the same edge as status or enable
    s_nxt.ists = (s_r.ists & ~clr) | set;
    s_nxt.irq  = |(s_nxt.ists & s_nxt.ien);

    // Read channel
    // Unmapped reads return zero with an error response
    if (s_r.rvalid && rready_in) begin
      s_nxt.rvalid = 1'b0;
    end
    if (arvalid_in && arready_out) begin
      rs          = sel_fn(araddr_in);
      s_nxt.rresp = `RESP_OKAY;
      unique case (rs)
        gp_timer_pkg::SEL_CTRL0: rv = s_r.ctrl[0];
        gp_timer_pkg::SEL_CTRL1: rv = s_r.ctrl[1];
        gp_timer_pkg::SEL_CTRL2: rv = s_r.ctrl[2];
        gp_timer_pkg::SEL_CNT0:  rv = s_r.cnt[0];
        gp_timer_pkg::SEL_CNT1:  rv = s_r.cnt[1];
        gp_timer_pkg::SEL_CNT2:  rv = s_r.cnt[2];
        gp_timer_pkg::SEL_ISTS:  rv = {13'h0000, s_r.ists};
        gp_timer_pkg::SEL_ICLR:  rv = 16'h0000;
        gp_timer_pkg::SEL_IEN:   rv = {13'h0000, s_r.ien};
        gp_timer_pkg::SEL_STAT:  rv = {9'h000, s_r.stb, s_r.otl};
        default:                 s_nxt.rresp = `RESP_SLVERR;
      endcase
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = {16'h0000, rv};
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  // Synchronous reset to all-zero state
  // Zero state leaves pins and latch idle low
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule
